// *** rsbm_map.vh ***
// Functional notes
// - Mode 00 or 11 bypasses; clock, sync output.
// - Mode 01 is slip buffer; clock input.
// - Slip mode: sync direction follows bit 2.
// - Mode 10 is FIFO; clock input, latency applied.
// - FIFO delays data by latency clock periods.
// - Latency ignored outside FIFO mode.
// - Sync direction bit read/write, resets to one.
`ifndef RSBM_MAP_VH
`define RSBM_MAP_VH
// Offsets are word indices; the byte address is four times the index
`define RSBM_OFF_SBCTL     10'h116
`define RSBM_OFF_LAT       10'h117
`define RSBM_OFF_STATUS    10'h118
`define RSBM_MODE_LSB      0
`define RSBM_MODE_MSB      1
`define RSBM_SDIR_BIT      2
`define RSBM_LAT_MSB       4
`define RSBM_SBCTL_RST     8'h07
`define RSBM_LAT_RST       8'h00
`define RSBM_MODE_BYP0     2'h0
`define RSBM_MODE_SLIP     2'h1
`define RSBM_MODE_FIFO     2'h2
`define RSBM_RESP_OKAY     2'h0
`define RSBM_RESP_SLVERR   2'h2
`endif

// *** rsbm_delay.v ***
`timescale 1ns/1ps
`default_nettype none
module rsbm_delay #(
  parameter DEPTH = 32,
  parameter LW    = 5
) (
  // Clock and reset
  input  wire          clk,
  input  wire          rst,
  // Shift control
  input  wire          shift,
  input  wire          din,
  input  wire [LW-1:0] lat,
  // Delayed data
  output reg           dout
);
  reg [DEPTH-1:0] line_r;
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_tap
      always @(posedge clk or posedge rst) begin
        if (rst)
          line_r[i] <= 1'b0;
        else if (shift)
          line_r[i] <= (i == 0) ? din : line_r[(i == 0) ? 0 : i - 1];
      end
    end
  endgenerate
  // Tap read combinationally: the output register downstream must not
  // add a period of its own, so latency zero matches slip mode
  always @* begin
    dout = (lat == {LW{1'b0}}) ? din : line_r[lat - 1'b1];
  end
endmodule
`default_nettype wire

// *** rsbm_top.v ***
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "rsbm_map.vh"
module rsbm_top #(
  parameter LW = 5
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // AXI4-Lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Receive serial clock pin
  input  wire        rx_serial_clock_pin_i,
  output reg         rx_serial_clock_pin_o,
  output wire        rx_serial_clock_pin_oe,
  // Receive frame boundary pin
  input  wire        rx_frame_boundary_pin_i,
  output reg         rx_frame_boundary_pin_o,
  output wire        rx_frame_boundary_pin_oe,
  // Framer side
  input  wire        rec_clk,
  input  wire        rec_data,
  input  wire        rec_sync,
  // System side
  output reg         sys_data,
  output reg         sys_sync
);
  // Registers
  reg  [7:0]    sbctl_r;
  reg  [7:0]    lat_r;
  reg  [11:0]   aw_addr_r;
  reg           aw_have_r;
  reg  [31:0]   w_data_r;
  reg  [3:0]    w_strb_r;
  reg           w_have_r;
  wire [1:0]    mode;
  wire          bypass;
  wire          fifo_mode;
  wire          sync_in;
  wire          do_write;

  assign mode      = sbctl_r[`RSBM_MODE_MSB:`RSBM_MODE_LSB];
  assign fifo_mode = (mode == `RSBM_MODE_FIFO);
  assign bypass    = !fifo_mode && (mode != `RSBM_MODE_SLIP);
  // Sync direction bit only matters with the buffer enabled
  assign sync_in   = !bypass && sbctl_r[`RSBM_SDIR_BIT];

  // Pin directions
  assign rx_serial_clock_pin_oe   = bypass;
  assign rx_frame_boundary_pin_oe = !sync_in;

  // Write channel: address and data accepted in either order
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
  assign do_write      = aw_have_r && w_have_r && !s_axi_bvalid;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_addr_r    <= 12'h000;
      aw_have_r    <= 1'b0;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      w_have_r     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RSBM_RESP_OKAY;
      sbctl_r      <= `RSBM_SBCTL_RST;
      lat_r        <= `RSBM_LAT_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r <= s_axi_awaddr;
        aw_have_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_have_r <= 1'b1;
      end
      if (do_write) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RSBM_RESP_OKAY;
        case (aw_addr_r[11:2])
          `RSBM_OFF_SBCTL: begin
            if (w_strb_r[0])
              sbctl_r <= w_data_r[7:0] & 8'h9F;
          end
          `RSBM_OFF_LAT: begin
            if (w_strb_r[0])
              lat_r <= w_data_r[7:0] & 8'h1F;
          end
          `RSBM_OFF_STATUS: begin
            s_axi_bresp <= `RSBM_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `RSBM_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel
  reg  [7:0] status_r;
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RSBM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RSBM_RESP_OKAY;
      case (s_axi_araddr[11:2])
        `RSBM_OFF_SBCTL:  s_axi_rdata <= {24'h000000, sbctl_r};
        `RSBM_OFF_LAT:    s_axi_rdata <= {24'h000000, lat_r};
        `RSBM_OFF_STATUS: s_axi_rdata <= {24'h000000, status_r};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RSBM_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Pin and framer inputs pass two flip-flops
  reg [1:0] sclk_s_r;
  reg [1:0] fsync_s_r;
  reg [1:0] rclk_s_r;
  reg [1:0] rdat_s_r;
  reg [1:0] rsyn_s_r;
  reg       sclk_d_r;
  reg       rclk_d_r;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_s_r  <= 2'h0;
      fsync_s_r <= 2'h0;
      rclk_s_r  <= 2'h0;
      rdat_s_r  <= 2'h0;
      rsyn_s_r  <= 2'h0;
      sclk_d_r  <= 1'b0;
      rclk_d_r  <= 1'b0;
    end else begin
      sclk_s_r  <= {sclk_s_r[0], rx_serial_clock_pin_i};
      fsync_s_r <= {fsync_s_r[0], rx_frame_boundary_pin_i};
      rclk_s_r  <= {rclk_s_r[0], rec_clk};
      rdat_s_r  <= {rdat_s_r[0], rec_data};
      rsyn_s_r  <= {rsyn_s_r[0], rec_sync};
      sclk_d_r  <= sclk_s_r[1];
      rclk_d_r  <= rclk_s_r[1];
    end
  end

  wire sclk_rise = sclk_s_r[1] && !sclk_d_r;
  wire rclk_rise = rclk_s_r[1] && !rclk_d_r;

  // Slip mechanics are outside this block: slip mode retimes one bit
  reg  slip_bit_r;
  reg  slip_sync_r;
  wire fifo_dout;
  wire sys_edge = bypass ? rclk_rise : sclk_rise;

  rsbm_delay #(
    .DEPTH (32),
    .LW    (LW)
  ) u_delay (
    .clk   (clk),
    .rst   (rst),
    .shift (fifo_mode && sclk_rise),
    .din   (slip_bit_r),
    .lat   (lat_r[LW-1:0]),
    .dout  (fifo_dout)
  );

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      slip_bit_r              <= 1'b0;
      slip_sync_r             <= 1'b0;
      sys_data                <= 1'b0;
      sys_sync                <= 1'b0;
      rx_serial_clock_pin_o   <= 1'b0;
      rx_frame_boundary_pin_o <= 1'b0;
      status_r                <= 8'h00;
    end else begin
      rx_serial_clock_pin_o <= rclk_s_r[1];
      if (rclk_rise) begin
        slip_bit_r  <= rdat_s_r[1];
        slip_sync_r <= rsyn_s_r[1];
      end
      rx_frame_boundary_pin_o <= slip_sync_r;
      if (sys_edge) begin
        // Latency only acts in FIFO mode
        sys_data <= fifo_mode ? fifo_dout : slip_bit_r;
        sys_sync <= sync_in ? fsync_s_r[1] : slip_sync_r;
      end
      status_r <= {5'h00, sync_in, fifo_mode, bypass};
    end
  end
endmodule
`default_nettype wire

// *** rsbm_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module rsbm_checker (
  // Clock, reset and bus handshakes
  input wire logic        clk, rst, s_axi_awvalid, s_axi_awready,
  input wire logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid,
  input wire logic        s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic        s_axi_rvalid, s_axi_rready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [31:0] s_axi_rdata,
  // Pin drive enables
  input wire logic        rx_serial_clock_pin_oe, rx_frame_boundary_pin_oe,
  // Framer clock and its copy on the serial clock pin
  input wire logic        rec_clk, rx_serial_clock_pin_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  byp_pins_a: assert property (rx_serial_clock_pin_oe |->
    rx_frame_boundary_pin_oe) else $error("sync pin not driven in bypass");
  rst_dirs_a: assert property ($fell(rst) |-> rx_frame_boundary_pin_oe
    && rx_serial_clock_pin_oe) else $error("pins not driven after reset");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read data late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  w_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) else $error("write taken while response pending");
  r_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  // Copy lags three edges: two synchroniser stages and the output flop
  clk_copy_a: assert property (!$past(rst, 3) |->
    rx_serial_clock_pin_o == $past(rec_clk, 3))
    else $error("serial clock copy wrong");
endmodule
bind rsbm_top rsbm_checker rsbm_checker_i (.*);
`default_nettype wire

// *** rsbm_backplane.sv ***
`timescale 1ns/1ps
`default_nettype none
module rsbm_backplane (
  // Clock runs only while the device takes it; parks low otherwise
  input  wire logic run,
  output var  logic sclk,
  output var  logic fsync
);
  int n = 0;
  initial sclk = 1'b0;
  initial fsync = 1'b0;
  always #62.5 if (run || sclk) sclk = ~sclk;
  always @(posedge sclk) begin
    n <= n + 1;
    fsync <= (n % 8 == 0);
  end
endmodule
`default_nettype wire

// *** rsbm_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rsbm_map.vh"
module rsbm_top_tb;
  logic clk = 0, rst = 1, rec_clk = 0, rec_data = 0, rec_sync = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [7:0] c;
  logic hold = 0, lvl = 0, slvl = 0;
  logic [1:0] br;
  logic [31:0] s_axi_wdata = 0, d, v;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, bp_sclk, bp_sync;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, sys_data, sys_sync, rx_serial_clock_pin_o;
  wire rx_serial_clock_pin_oe, rx_frame_boundary_pin_o;
  wire rx_frame_boundary_pin_oe;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  // Wire level: whoever enables drives it
  wire rx_serial_clock_pin_i = rx_serial_clock_pin_oe ?
    rx_serial_clock_pin_o : bp_sclk;
  wire rx_frame_boundary_pin_i = rx_frame_boundary_pin_oe ?
    rx_frame_boundary_pin_o : bp_sync;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  logic [1:0] rr;
  localparam logic [11:0] SB = 12'(`RSBM_OFF_SBCTL * 4);
  localparam logic [11:0] LT = 12'(`RSBM_OFF_LAT * 4);
  rsbm_top rsbm_top_i (.*);
  rsbm_backplane rsbm_backplane_i (.run(!rx_serial_clock_pin_oe),
    .sclk(bp_sclk), .fsync(bp_sync));
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    // Held levels let a single step be timed through the buffer
    rec_data <= hold ? lvl : 1'($urandom);
    rec_sync <= hold ? slvl : (cyc[7:0] == 8'h00);
    // Fast framer clock so a new bit lands well inside a serial period
    if (cyc[0]) rec_clk <= ~rec_clk;
    // Longest latency runs need under ten thousand cycles
    if (cyc == 20000) begin
      error_cnt++;
      finish_test;
    end
  end
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] dv);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dv;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while ((s_axi_awvalid && !s_axi_awready) ||
               (s_axi_wvalid && !s_axi_wready));
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    br = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] dv);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    dv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  // Expected {sync enable, clock enable} for a control value
  function automatic logic [31:0] exp_oe(input logic [7:0] cv);
    logic byp;
    byp = (cv[1:0] == 2'h0) || (cv[1:0] == 2'h3);
    return {30'h0, byp || !cv[2], byp};
  endfunction
  // Hold a bit, step it, count serial periods until it reaches sys_data
  task automatic lat_run(input logic [7:0] cv, input logic [4:0] lt);
    int k;
    logic b;
    b = 1'($urandom);
    wr(SB, {24'h0, cv});
    wr(LT, {27'h0, lt});
    hold <= 1;
    lvl <= b;
    slvl <= ~b;
    repeat (lt + 3) @(negedge bp_sclk);
    ck(sys_data, b);
    lvl <= ~b;
    k = 0;
    do begin
      @(negedge bp_sclk);
      k++;
    end while (sys_data !== ~b && k < 40);
    ck(k, (cv[1:0] == 2'h2) ? lt + 1 : 1);
    ck(sys_sync, cv[2] ? bp_sync : slvl);
    if (!cv[2]) ck(rx_frame_boundary_pin_o, slvl);
  endtask
  task automatic finish_test;
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    v = $urandom(32'h23C7F3F2);
    repeat (6) @(posedge clk);
    rst <= 0;
    rd(SB, d); ck(d, 32'h07);
    ck({rx_frame_boundary_pin_oe, rx_serial_clock_pin_oe}, 32'h3);
    rd(LT, d); ck(d, 32'h00);
    for (int i = 0; i < 16; i++) begin
      v = $urandom;
      c = {v[7:3], 3'(i)};
      wr(SB, {v[31:8], c});
      wr(LT, v); // Latency written in every mode must not move the pins
      repeat (2) @(posedge clk);
      ck({rx_frame_boundary_pin_oe, rx_serial_clock_pin_oe}, exp_oe(c));
      rd(SB, d); ck(d, {24'h0, c & 8'h9F});
      rd(LT, d); ck(d, {27'h0, v[4:0]});
    end
    lat_run(8'h01, 5'($urandom));
    lat_run(8'h05, 5'($urandom));
    lat_run(8'h02, 5'h00);
    lat_run(8'h06, 5'h1F);
    repeat (2) lat_run(8'h02, 5'($urandom));
    ck(br, `RSBM_RESP_OKAY);
    s_axi_wstrb <= 4'hE;
    wr(SB, 32'h0000_0000);
    s_axi_wstrb <= 4'hF;
    rd(SB, d);
    ck(d, 32'h02);
    wr(12'h000, 32'h0000_0000);
    ck(br, `RSBM_RESP_SLVERR);
    rd(12'h000, d);
    ck(d, 32'h0);
    ck(rr, `RSBM_RESP_SLVERR);
    finish_test;
  end
endmodule
`default_nettype wire
